/* File: verilog/ccl_current_cal.sv */
// Functional notes
// - Ceiling reads 5.5 V with range bit 0, 2.75 V with range bit 1.
// - Setpoint above ceiling raises a logic fault and is clamped to ceiling.
// - Same write sets the setpoint-clamp warning, status bit 3.
// - Ceiling register is read-only two-byte linear-16 unsigned; writes ignored.
// - Output sense gain holds milliohms in 5/11 linear format.
// - Temperature coefficient is signed 16-bit ppm per degree.
// - Effective gain is gain times (1 + tempco times (temp - 27)).
// - Compensated gain feeds readings, input channel reading and current limits.
// - Self-heat starts at zero, then accumulates a signed increment per one-second tick.
// - Increment is (power times theta minus inductor temperature) times tau inverse.
// - Self-heat updates once per second.
// - Sensed temperature outside -50..150 C is replaced by -50 C.
// - Self-heat register saturates to 0..50 C.
// - Theta or tau inverse at or below zero forces self-heat to zero.
// - Tau inverse at least one sets self-heat to theta times power.
// - Fault limit rounds up to one of eight thresholds over gain, 25..50 mV low.
// - Mode bit 7 picks range; high range spans 37.5..75 mV.
// - Current limit condition signals output overcurrent fault on peak current.
// - Peak limits scale by the same temperature factor as the gain.
// - Fault limit is ignored during turn-on and turn-off ramps.
// - Averaged output current above warn limit sets status bits and alert.
// - Warnings may lag the crossing by up to 80 ms.
// - Input current above its warn limit sets input status bits and alert.
`timescale 1ns/1ns
module ccl_current_cal
   import ccl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = CCL_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [15:0] cmd_wdata,
   output logic [15:0] cmd_rdata_r,
   output logic cmd_ack_r,
   input wire logic pwm_config_range,
   input wire logic pwm_mode_range,
   input wire logic adc_sample,
   input wire logic [15:0] temp_l11,
   input wire logic [15:0] iout_sense_l11,
   input wire logic [15:0] iin_sense_l11,
   input wire logic ramp_active,
   input wire logic current_limit_pin,
   input wire logic status_clear,
   output logic [15:0] vout_setpoint_r,
   output logic cml_fault_r,
   output logic setpoint_clamp_warning_r,
   output logic iout_warn_r,
   output logic iin_warn_r,
   output logic status_nota_r,
   output logic status_other_r,
   output logic status_word_iout_r,
   output logic status_word_input_r,
   output logic alert_n_r,
   output logic oc_fault_r,
   output logic [2:0] oc_thresh_sel_r,
   output logic [31:0] iout_reading_r,
   output logic [31:0] channel_input_current_reading_r,
   output logic [31:0] gain_eff_r
);

   // ------------------------------------------------------------
   // Command registers
   // ------------------------------------------------------------
   logic [15:0] out_gain_r;
   logic [15:0] oc_fault_lim_r;
   logic [15:0] oc_warn_lim_r;
   logic [15:0] iin_warn_lim_r;
   logic [15:0] tau_inv_r;
   logic [15:0] theta_r;
   logic [15:0] in_gain_r;
   logic [15:0] tempco_r;
   logic [15:0] vmax;
   logic vout_over;
   ccl_fix_t sh_r;

   // Ceiling follows the output range bit
   assign vmax = pwm_config_range ? CCL_VMAX_NARROW : CCL_VMAX_WIDE;
   assign vout_over = cmd_wr && (cmd_code == CCL_CMD_VOUT_COMMAND) && (cmd_wdata > vmax);

   // Host writes; ceiling and self-heat codes have no storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vout_setpoint_r <= CCL_RST_VOUT_COMMAND;
         out_gain_r <= CCL_RST_OUT_GAIN;
         oc_fault_lim_r <= CCL_RST_OC_FAULT;
         oc_warn_lim_r <= CCL_RST_OC_WARN;
         iin_warn_lim_r <= CCL_RST_IIN_WARN;
         tau_inv_r <= CCL_RST_TAU_INV;
         theta_r <= CCL_RST_THETA;
         in_gain_r <= CCL_RST_IN_GAIN;
         tempco_r <= CCL_RST_TEMPCO;
      end else if (cmd_wr) begin
         if (cmd_code == CCL_CMD_VOUT_COMMAND) begin
            vout_setpoint_r <= vout_over ? vmax : cmd_wdata;
         end else if (cmd_code == CCL_CMD_OUT_GAIN) begin
            out_gain_r <= cmd_wdata;
         end else if (cmd_code == CCL_CMD_OC_FAULT) begin
            oc_fault_lim_r <= cmd_wdata;
         end else if (cmd_code == CCL_CMD_OC_WARN) begin
            oc_warn_lim_r <= cmd_wdata;
         end else if (cmd_code == CCL_CMD_IIN_WARN) begin
            iin_warn_lim_r <= cmd_wdata;
         end else if (cmd_code == CCL_CMD_TAU_INV) begin
            tau_inv_r <= cmd_wdata;
         end else if (cmd_code == CCL_CMD_THETA) begin
            theta_r <= cmd_wdata;
         end else if (cmd_code == CCL_CMD_IN_GAIN) begin
            in_gain_r <= cmd_wdata;
         end else if (cmd_code == CCL_CMD_TEMPCO) begin
            tempco_r <= cmd_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [15:0] rd_nxt;
   logic hit_nxt;

   always_comb begin
      rd_nxt = 16'h0000;
      hit_nxt = 1'b1;
      if (cmd_code == CCL_CMD_VOUT_COMMAND) begin
         rd_nxt = vout_setpoint_r;
      end else if (cmd_code == CCL_CMD_OUT_GAIN) begin
         rd_nxt = out_gain_r;
      end else if (cmd_code == CCL_CMD_OC_FAULT) begin
         rd_nxt = oc_fault_lim_r;
      end else if (cmd_code == CCL_CMD_OC_WARN) begin
         rd_nxt = oc_warn_lim_r;
      end else if (cmd_code == CCL_CMD_IIN_WARN) begin
         rd_nxt = iin_warn_lim_r;
      end else if (cmd_code == CCL_CMD_VOUT_MAX) begin
         rd_nxt = vmax;
      end else if (cmd_code == CCL_CMD_SELF_HEAT) begin
         rd_nxt = {CCL_SH_EXP, 11'(sh_r >>> CCL_SH_SHIFT)};
      end else if (cmd_code == CCL_CMD_TAU_INV) begin
         rd_nxt = tau_inv_r;
      end else if (cmd_code == CCL_CMD_THETA) begin
         rd_nxt = theta_r;
      end else if (cmd_code == CCL_CMD_IN_GAIN) begin
         rd_nxt = in_gain_r;
      end else if (cmd_code == CCL_CMD_TEMPCO) begin
         rd_nxt = tempco_r;
      end else begin
         hit_nxt = 1'b0;
      end
   end

   // Unknown codes answer zero data with no acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_rdata_r <= 16'h0000;
         cmd_ack_r <= 1'b0;
      end else begin
         cmd_ack_r <= (cmd_rd || cmd_wr) && hit_nxt;
         if (cmd_rd) begin
            cmd_rdata_r <= rd_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // Temperature compensation of both sense gains
   // ------------------------------------------------------------
   ccl_fix_t temp_fix;
   ccl_fix_t ts_fix;
   ccl_fix_t t_ind;
   ccl_wide_t factor;
   ccl_wide_t og_eff;
   ccl_wide_t ig_eff;
   ccl_wide_t og_eff_r;
   ccl_wide_t ig_eff_r;

   // Purely combinational, so any register or reading change shows next cycle
   always_comb begin
      temp_fix = ccl_l11_to_fix(temp_l11);
      ts_fix = (temp_fix >= CCL_TS_MIN && temp_fix <= CCL_TS_MAX) ? temp_fix : CCL_TS_MIN;
      t_ind = sh_r + ts_fix;
      factor = CCL_ONE_Q20 + ((ccl_wide_t'($signed(tempco_r)) * ccl_wide_t'(t_ind - CCL_T_NOM)
               * CCL_TC_K) >>> CCL_TC_SH);
      og_eff = (ccl_wide_t'(ccl_l11_to_fix(out_gain_r)) * factor) >>> CCL_Q20;
      ig_eff = (ccl_wide_t'(ccl_l11_to_fix(in_gain_r)) * factor) >>> CCL_Q20;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         og_eff_r <= '0;
         ig_eff_r <= '0;
         gain_eff_r <= 32'h0000_0000;
      end else begin
         og_eff_r <= og_eff;
         ig_eff_r <= ig_eff;
         gain_eff_r <= 32'(og_eff);
      end
   end

   // ------------------------------------------------------------
   // Peak limit quantisation
   // ------------------------------------------------------------
   ccl_wide_t need_dmv;
   logic [CCL_NTHR-1:0] thr_ok;
   logic [2:0] sel_nxt;

   // Limit in amperes times gain gives the sense voltage to cover
   assign need_dmv = (ccl_wide_t'(ccl_l11_to_fix(oc_fault_lim_r)) * og_eff_r * CCL_DMV_PER_MV)
                     >>> CCL_Q20;

   generate
      for (genvar i = 0; i < CCL_NTHR; i++) begin : g_thr
         assign thr_ok[i] = ccl_wide_t'({1'b0, pwm_mode_range ? CCL_THR_HI[i] : CCL_THR_LO[i]})
                            >= need_dmv;
      end
   endgenerate

   // Lowest covering threshold; too large a limit clamps to the top one
   always_comb begin
      sel_nxt = 3'(CCL_NTHR - 1);
      for (int j = CCL_NTHR - 1; j >= 0; j--) begin
         if (thr_ok[j]) begin
            sel_nxt = 3'(j);
         end
      end
   end

   // Current-limit pin is asynchronous to clk
   logic lim_meta_r;
   logic lim_sync_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lim_meta_r <= 1'b0;
         lim_sync_r <= 1'b0;
         oc_thresh_sel_r <= 3'h0;
         oc_fault_r <= 1'b0;
      end else begin
         lim_meta_r <= current_limit_pin;
         lim_sync_r <= lim_meta_r;
         oc_thresh_sel_r <= sel_nxt;
         oc_fault_r <= lim_sync_r && !ramp_active;
      end
   end

   // ------------------------------------------------------------
   // Current readings through the shared divider
   // ------------------------------------------------------------
   ccl_seq_t seq_r;
   logic div_start;
   logic div_done;
   logic [CCL_DIV_W-1:0] div_num;
   logic [CCL_DIV_W-1:0] div_den;
   logic [CCL_DIV_W-1:0] div_quo;
   ccl_fix_t vsense_fix;

   // Negative sense voltages read as zero current
   // Operands are set up for the division being started: input channel follows the output one
   assign vsense_fix = ccl_l11_to_fix((seq_r == CCL_SEQ_IOUT) ? iin_sense_l11 : iout_sense_l11);
   assign div_num = (vsense_fix > CCL_FIX_ZERO) ? CCL_DIV_W'(vsense_fix <<< CCL_QF) : '0;
   assign div_den = CCL_DIV_W'((seq_r == CCL_SEQ_IOUT) ? ig_eff_r : og_eff_r);
   assign div_start = (seq_r == CCL_SEQ_IDLE && adc_sample)
                      || (seq_r == CCL_SEQ_IOUT && div_done);

   ccl_divider u_div (
      .clk(clk),
      .rst_n(rst_n),
      .start(div_start),
      .dividend(div_num),
      .divisor(div_den),
      .done_r(div_done),
      .quotient_r(div_quo)
   );

   // A sample request during a division is dropped; the next one catches up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_r <= CCL_SEQ_IDLE;
         iout_reading_r <= 32'h0000_0000;
         channel_input_current_reading_r <= 32'h0000_0000;
      end else begin
         case (seq_r)
            CCL_SEQ_IDLE: begin
               if (adc_sample) begin
                  seq_r <= CCL_SEQ_IOUT;
               end
            end
            CCL_SEQ_IOUT: begin
               if (div_done) begin
                  iout_reading_r <= 32'(div_quo);
                  seq_r <= CCL_SEQ_IIN;
               end
            end
            CCL_SEQ_IIN: begin
               if (div_done) begin
                  channel_input_current_reading_r <= 32'(div_quo);
                  seq_r <= CCL_SEQ_IDLE;
               end
            end
            default: begin
               seq_r <= CCL_SEQ_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Status flags and alert
   // ------------------------------------------------------------
   logic iout_over;
   logic iin_over;
   logic cml_nxt;
   logic clamp_nxt;
   logic iout_warn_nxt;
   logic iin_warn_nxt;

   assign iout_over = div_done && (seq_r == CCL_SEQ_IOUT)
                      && (ccl_fix_t'(div_quo) > ccl_l11_to_fix(oc_warn_lim_r));
   assign iin_over = div_done && (seq_r == CCL_SEQ_IIN)
                     && (ccl_fix_t'(div_quo) > ccl_l11_to_fix(iin_warn_lim_r));
   // A new event in the clearing cycle keeps its flag
   assign cml_nxt = vout_over || (cml_fault_r && !status_clear);
   assign clamp_nxt = vout_over || (setpoint_clamp_warning_r && !status_clear);
   assign iout_warn_nxt = iout_over || (iout_warn_r && !status_clear);
   assign iin_warn_nxt = iin_over || (iin_warn_r && !status_clear);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cml_fault_r <= 1'b0;
         setpoint_clamp_warning_r <= 1'b0;
         iout_warn_r <= 1'b0;
         iin_warn_r <= 1'b0;
         status_nota_r <= 1'b0;
         status_other_r <= 1'b0;
         status_word_iout_r <= 1'b0;
         status_word_input_r <= 1'b0;
         alert_n_r <= 1'b1;
      end else begin
         cml_fault_r <= cml_nxt;
         setpoint_clamp_warning_r <= clamp_nxt;
         iout_warn_r <= iout_warn_nxt;
         iin_warn_r <= iin_warn_nxt;
         status_nota_r <= clamp_nxt || iout_warn_nxt;
         status_other_r <= iin_warn_nxt;
         status_word_iout_r <= iout_warn_nxt;
         status_word_input_r <= iin_warn_nxt;
         alert_n_r <= !(cml_nxt || clamp_nxt || iout_warn_nxt || iin_warn_nxt);
      end
   end

   // ------------------------------------------------------------
   // Inductor self-heating model
   // ------------------------------------------------------------
   logic [23:0] tick_cnt_r;
   logic tick;
   ccl_fix_t theta_fix;
   ccl_fix_t tau_fix;
   ccl_wide_t pwr;
   ccl_wide_t tp;
   ccl_wide_t sh_calc;
   ccl_fix_t sh_nxt;

   assign tick = (tick_cnt_r == 24'(TICK_CYCLES - 1));

   // One-second update pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= 24'h000000;
      end else if (tick) begin
         tick_cnt_r <= 24'h000000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 24'h000001;
      end
   end

   // Power in watts from averaged current and the sense voltage in millivolts
   always_comb begin
      theta_fix = ccl_l11_to_fix(theta_r);
      tau_fix = ccl_l11_to_fix(tau_inv_r);
      pwr = (((ccl_wide_t'($signed({1'b0, iout_reading_r})) * ccl_wide_t'(ccl_l11_to_fix(iout_sense_l11)))
             >>> CCL_QF)
            * CCL_MW_TO_W_K) >>> CCL_Q20;
      tp = (ccl_wide_t'(theta_fix) * pwr) >>> CCL_QF;
      if (theta_fix <= CCL_FIX_ZERO || tau_fix <= CCL_FIX_ZERO) begin
         sh_calc = '0;
      end else if (tau_fix >= CCL_TAU_ONE) begin
         sh_calc = tp;
      end else begin
         sh_calc = ccl_wide_t'(sh_r) + (((tp - ccl_wide_t'(t_ind)) * ccl_wide_t'(tau_fix)) >>> CCL_QF);
      end
      if (sh_calc < ccl_wide_t'(CCL_FIX_ZERO)) begin
         sh_nxt = CCL_FIX_ZERO;
      end else if (sh_calc > ccl_wide_t'(CCL_SH_MAX)) begin
         sh_nxt = CCL_SH_MAX;
      end else begin
         sh_nxt = ccl_fix_t'(sh_calc);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_r <= CCL_FIX_ZERO;
      end else if (tick) begin
         sh_r <= sh_nxt;
      end
   end

endmodule

/* File: verilog/ccl_pkg.sv */
package ccl_pkg;

   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CCL_CMD_VOUT_COMMAND = 8'h21;
   localparam logic [7:0] CCL_CMD_OUT_GAIN = 8'h38;
   localparam logic [7:0] CCL_CMD_OC_FAULT = 8'h46;
   localparam logic [7:0] CCL_CMD_OC_WARN = 8'h4A;
   localparam logic [7:0] CCL_CMD_IIN_WARN = 8'h5D;
   localparam logic [7:0] CCL_CMD_VOUT_MAX = 8'hA5;
   localparam logic [7:0] CCL_CMD_SELF_HEAT = 8'hB8;
   localparam logic [7:0] CCL_CMD_TAU_INV = 8'hB9;
   localparam logic [7:0] CCL_CMD_THETA = 8'hBA;
   localparam logic [7:0] CCL_CMD_IN_GAIN = 8'hE8;
   localparam logic [7:0] CCL_CMD_TEMPCO = 8'hF6;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] CCL_RST_VOUT_COMMAND = 16'h1000;
   localparam logic [15:0] CCL_RST_OUT_GAIN = 16'hBB9A;
   localparam logic [15:0] CCL_RST_OC_FAULT = 16'hDBB8;
   localparam logic [15:0] CCL_RST_OC_WARN = 16'hDA80;
   localparam logic [15:0] CCL_RST_IIN_WARN = 16'hD280;
   localparam logic [15:0] CCL_RST_TAU_INV = 16'h8000;
   localparam logic [15:0] CCL_RST_THETA = 16'h8000;
   localparam logic [15:0] CCL_RST_IN_GAIN = 16'hCA80;
   localparam logic [15:0] CCL_RST_TEMPCO = 16'h0F3C;

   // Ceiling in linear-16 unsigned, exponent -12
   localparam logic [15:0] CCL_VMAX_WIDE = 16'h5800;
   localparam logic [15:0] CCL_VMAX_NARROW = 16'h2C00;

   // ------------------------------------------------------------
   // Fixed point: signed, 10 fraction bits
   // ------------------------------------------------------------
   typedef logic signed [47:0] ccl_fix_t;
   typedef logic signed [63:0] ccl_wide_t;
   localparam int CCL_QF = 10;
   localparam int CCL_Q20 = 20;
   localparam int CCL_TC_SH = 26;
   localparam ccl_wide_t CCL_TC_K = 64'sh10C6F;
   localparam ccl_wide_t CCL_ONE_Q20 = 64'sh100000;
   localparam ccl_wide_t CCL_MW_TO_W_K = 64'sh419;
   localparam ccl_wide_t CCL_DMV_PER_MV = 64'shA;
   localparam ccl_fix_t CCL_T_NOM = 48'sh6C00;
   localparam ccl_fix_t CCL_TS_MIN = -48'shC800;
   localparam ccl_fix_t CCL_TS_MAX = 48'sh25800;
   localparam ccl_fix_t CCL_SH_MAX = 48'shC800;
   localparam ccl_fix_t CCL_TAU_ONE = 48'sh400;
   localparam ccl_fix_t CCL_FIX_ZERO = 48'sh0;
   localparam logic [4:0] CCL_SH_EXP = 5'h1C;
   localparam int CCL_SH_SHIFT = 6;

   // Peak current thresholds in tenths of a millivolt
   localparam int CCL_NTHR = 8;
   localparam logic [15:0] CCL_THR_LO [CCL_NTHR] = '{16'h00FA, 16'h011E, 16'h0141, 16'h0165,
                                                    16'h0189, 16'h01AD, 16'h01D0, 16'h01F4};
   localparam logic [15:0] CCL_THR_HI [CCL_NTHR] = '{16'h0177, 16'h01AD, 16'h01E2, 16'h0218,
                                                    16'h024D, 16'h0283, 16'h02B8, 16'h02EE};

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CCL_CLK_PERIOD_NS = 32'h64;
   localparam int CCL_SH_PERIOD_MS = 32'h3E8;
   localparam int CCL_NS_PER_MS = 32'hF4240;
   localparam int CCL_TICK_CYCLES = CCL_SH_PERIOD_MS * CCL_NS_PER_MS / CCL_CLK_PERIOD_NS;
   localparam int CCL_DIV_W = 48;

   typedef enum logic [1:0] {
      CCL_SEQ_IDLE = 2'b00,
      CCL_SEQ_IOUT = 2'b01,
      CCL_SEQ_IIN = 2'b11
   } ccl_seq_t;

   // Linear 5s/11s word to fixed point
   function automatic ccl_fix_t ccl_l11_to_fix(input logic [15:0] w);
      logic signed [5:0] sh;
      ccl_fix_t m;
      sh = $signed({w[15], w[15:11]}) + 6'sh0A;
      m = ccl_fix_t'($signed(w[10:0]));
      if (sh >= 6'sh00) begin
         ccl_l11_to_fix = m <<< sh;
      end else begin
         ccl_l11_to_fix = m >>> (6'(-sh));
      end
   endfunction

endpackage

/* File: verilog/ccl_divider.sv */
`timescale 1ns/1ns
module ccl_divider
   import ccl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [CCL_DIV_W-1:0] dividend,
   input wire logic [CCL_DIV_W-1:0] divisor,
   output logic done_r,
   output logic [CCL_DIV_W-1:0] quotient_r
);

   // ------------------------------------------------------------
   // Serial restoring divider, one quotient bit per cycle
   // ------------------------------------------------------------
   logic [CCL_DIV_W:0] rem_r;
   logic [CCL_DIV_W-1:0] den_r;
   logic [5:0] cnt_r;
   logic [CCL_DIV_W:0] shifted;

   assign shifted = {rem_r[CCL_DIV_W-1:0], quotient_r[CCL_DIV_W-1]};

   // Area traded for latency: 48 cycles per quotient is far inside a sample period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rem_r <= '0;
         den_r <= '0;
         cnt_r <= '0;
         quotient_r <= '0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            rem_r <= '0;
            den_r <= divisor;
            quotient_r <= dividend;
            cnt_r <= 6'(CCL_DIV_W);
         end else if (cnt_r != 6'h00) begin
            cnt_r <= cnt_r - 6'h01;
            done_r <= (cnt_r == 6'h01);
            if (shifted >= {1'b0, den_r}) begin
               rem_r <= shifted - {1'b0, den_r};
               quotient_r <= {quotient_r[CCL_DIV_W-2:0], 1'b1};
            end else begin
               rem_r <= shifted;
               quotient_r <= {quotient_r[CCL_DIV_W-2:0], 1'b0};
            end
         end
      end
   end

endmodule

/* File: test/ccl_current_cal_sva.sv */
`timescale 1ns/1ns
module ccl_current_cal_sva
   import ccl_pkg::*;
(
   input logic clk,
   input logic rst_n,
   input logic [7:0] cmd_code,
   input logic cmd_wr,
   input logic cmd_rd,
   input logic [15:0] cmd_wdata,
   input logic [15:0] cmd_rdata_r,
   input logic pwm_config_range,
   input logic ramp_active,
   input logic current_limit_pin,
   input logic [15:0] vout_setpoint_r,
   input logic cml_fault_r,
   input logic setpoint_clamp_warning_r,
   input logic iout_warn_r,
   input logic iin_warn_r,
   input logic status_word_iout_r,
   input logic status_other_r,
   input logic alert_n_r,
   input logic oc_fault_r
);
   // ----
   // Checks
   // ----
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Ceiling model
   wire [15:0] ceil_w = pwm_config_range ? CCL_VMAX_NARROW : CCL_VMAX_WIDE;
   wire over_w = cmd_wr && cmd_code == CCL_CMD_VOUT_COMMAND && cmd_wdata > ceil_w;
   chk_ceiling_read: assert property (cmd_rd && cmd_code == CCL_CMD_VOUT_MAX |=> cmd_rdata_r == $past(ceil_w))
      else $error("bad ceiling");
   chk_setpoint_clamp: assert property (over_w |=> cml_fault_r && vout_setpoint_r == $past(ceil_w))
      else $error("no clamp");
   chk_clamp_warn: assert property (over_w |=> setpoint_clamp_warning_r && !alert_n_r)
      else $error("no clamp warn");
   chk_iout_status: assert property (status_word_iout_r == iout_warn_r && (iout_warn_r -> !alert_n_r))
      else $error("iout status");
   chk_iin_status: assert property (status_other_r == iin_warn_r && (iin_warn_r -> !alert_n_r))
      else $error("iin status");
   chk_ramp_ignore: assert property (ramp_active |=> !oc_fault_r)
      else $error("ramp fault");
   chk_limit_fault: assert property ((current_limit_pin && !ramp_active) [*4] |=> oc_fault_r)
      else $error("no limit fault");
   chk_no_limit: assert property (!current_limit_pin [*4] |=> !oc_fault_r)
      else $error("stray fault");
endmodule
bind ccl_current_cal ccl_current_cal_sva u_sva (.*);

/* File: test/ccl_host_model.sv */
`timescale 1ns/1ns
module ccl_host_model (
   input wire logic clk,
   output logic [7:0] cmd_code,
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [15:0] cmd_wdata,
   input logic cmd_ack_r,
   input logic [15:0] cmd_rdata_r
);
   // Idle bus at time zero
   initial begin
      {cmd_code, cmd_wr, cmd_rd, cmd_wdata} = 26'h0;
   end
   // One-cycle request, fields scrambled after
   task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d, output logic [15:0] r, output logic a);
      @(posedge clk);
      cmd_code <= c;
      cmd_wdata <= d;
      {cmd_wr, cmd_rd} <= {wr, !wr};
      @(posedge clk);
      {cmd_wr, cmd_rd} <= 2'b00;
      cmd_code <= ~c;
      cmd_wdata <= ~d;
      @(posedge clk);
      r = cmd_rdata_r;
      a = cmd_ack_r;
   endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ns
module tb;
   logic clk, rst_n, pwm_config_range, pwm_mode_range, adc_sample, ramp_active, current_limit_pin, status_clear;
   logic cmd_wr, cmd_rd, cmd_ack_r, cml_fault_r, setpoint_clamp_warning_r, iout_warn_r, iin_warn_r, alert_n_r;
   logic status_nota_r, status_other_r, status_word_iout_r, status_word_input_r, oc_fault_r, ack;
   logic [2:0] oc_thresh_sel_r;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata_r, temp_l11, iout_sense_l11, iin_sense_l11, vout_setpoint_r, rv;
   logic [31:0] iout_reading_r, channel_input_current_reading_r, gain_eff_r;
   int err_count = 0, compares = 0, cyc_n = 0;
   // ----
   // Harness
   // ----
   ccl_current_cal #(.TICK_CYCLES(200)) u_ccl_current_cal (.*);
   ccl_host_model u_ccl_host_model (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 8000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      u_ccl_host_model.xfer(1'b1, c, d, rv, ack);
   endtask
   task automatic rd(input logic [7:0] c);
      u_ccl_host_model.xfer(1'b0, c, 16'h0, rv, ack);
   endtask
   task automatic pulse_clear();
      status_clear <= 1'b1;
      cyc(1);
      status_clear <= 1'b0;
      cyc(1);
   endtask
   // Spacing above 99 cycles
   task automatic samp(input logic [15:0] vo, input logic [15:0] vi);
      iout_sense_l11 <= vo;
      iin_sense_l11 <= vi;
      adc_sample <= 1'b1;
      cyc(1);
      adc_sample <= 1'b0;
      cyc(110);
   endtask
   task automatic t_regs();
      logic [7:0] c [8] = '{8'h38, 8'h46, 8'h4A, 8'h5D, 8'hB9, 8'hBA, 8'hE8, 8'hF6};
      logic [15:0] r [8] = '{16'hBB9A, 16'hDBB8, 16'hDA80, 16'hD280, 16'h8000, 16'h8000, 16'hCA80, 16'h0F3C};
      for (int i = 0; i < 8; i++) begin
         rd(c[i]);
         chk({ack, rv}, {1'b1, r[i]});
         wr(c[i], {8'h80, 8'(i)});
         rd(c[i]);
         chk(rv, {8'h80, 8'(i)});
         wr(c[i], r[i]);
      end
      rd(8'h00);
      chk({ack, rv}, 17'h0);
      wr(8'hA5, 16'h0000);
      rd(8'hA5);
      chk(rv, 16'h5800);
      $display("t_regs done");
   endtask
   task automatic t_ceiling();
      pwm_config_range <= 1'b1;
      rd(8'hA5);
      chk(rv, 16'h2C00);
      wr(8'h21, 16'h2C00);
      chk({vout_setpoint_r, cml_fault_r, alert_n_r}, {16'h2C00, 2'b01});
      wr(8'h21, 16'h2C01);
      chk({vout_setpoint_r, cml_fault_r, setpoint_clamp_warning_r, status_nota_r, alert_n_r}, 20'h2C00E);
      pulse_clear();
      chk({cml_fault_r, setpoint_clamp_warning_r, alert_n_r}, 3'b001);
      pwm_config_range <= 1'b0;
      wr(8'h21, 16'h1000);
      $display("t_ceiling done");
   endtask
   task automatic t_warn();
      samp(16'h0014, 16'h0014);
      chk({iout_warn_r, iin_warn_r, alert_n_r}, 3'b001);
      wr(8'h5D, 16'h0019);
      samp(16'h0064, 16'h0064);
      chk({iout_warn_r, status_word_iout_r, status_nota_r, iin_warn_r, alert_n_r}, 5'b11100);
      wr(8'h5D, 16'h000F);
      samp(16'h0064, 16'h0064);
      chk({iin_warn_r, status_other_r, status_word_input_r}, 3'b111);
      chk({iout_reading_r[15:0], channel_input_current_reading_r[15:0]}, 32'hDE205000);
      wr(8'h5D, 16'hD280);
      pulse_clear();
      $display("t_warn done");
   endtask
   task automatic t_peak();
      wr(8'h46, 16'hDA80);
      cyc(1);
      chk(oc_thresh_sel_r, 3'h4);
      pwm_mode_range <= 1'b1;
      cyc(3);
      chk(oc_thresh_sel_r, 3'h0);
      wr(8'h46, 16'hDBB8);
      cyc(1);
      chk(oc_thresh_sel_r, 3'h3);
      ramp_active <= 1'b1;
      current_limit_pin <= 1'b1;
      cyc(6);
      chk(oc_fault_r, 1'b0);
      ramp_active <= 1'b0;
      cyc(6);
      chk(oc_fault_r, 1'b1);
      current_limit_pin <= 1'b0;
      $display("t_peak done");
   endtask
   task automatic t_gain();
      wr(8'h38, 16'h0002);
      wr(8'hF6, 16'h0000);
      chk(gain_eff_r, 32'h800);
      wr(8'hF6, 16'h2710);
      temp_l11 <= 16'h007F;
      cyc(4);
      chk(32'(gain_eff_r > 32'hFF9 && gain_eff_r < 32'h1007), 1);
      temp_l11 <= 16'h00C8;
      cyc(4);
      chk(32'(gain_eff_r > 32'h1D0 && gain_eff_r < 32'h1DE), 1);
      temp_l11 <= 16'h001B;
      wr(8'hB9, 16'h0001);
      wr(8'hBA, 16'h0014);
      samp(16'h0064, 16'h0000);
      cyc(250);
      rd(8'hB8);
      chk(rv[10:0], 11'h320);
      wr(8'hBA, 16'h0000);
      cyc(250);
      rd(8'hB8);
      chk(rv[10:0], 11'h000);
      $display("t_gain done");
   endtask
   initial begin
      {rst_n, pwm_config_range, pwm_mode_range, adc_sample, ramp_active, current_limit_pin, status_clear} = 7'h0;
      {temp_l11, iout_sense_l11, iin_sense_l11} = 48'h001B_0000_0000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      t_regs();
      t_ceiling();
      t_warn();
      t_peak();
      t_gain();
      end_of_test();
   end
endmodule
